/* rtl/lcac_top.sv */
// Compatibility, channel, network and address configuration block of a radio node.
//
// Behaviour
// - Compat TX clear: payload limit from header, addresses, encryption; best 116.
// - Compat TX clear: several active messages, each to a distinct destination.
// - Compat TX set: payload fixed at 95 encrypted, 100 plain.
// - Compat TX set: only one transmit message active at a time.
// - Compat discovery clear: directed discovery ends on its single reply.
// - Compat discovery clear: a directed discovery with no reply before timeout gives an error.
// - Compat discovery set: directed discovery lasts to timeout, configuration writes refused.
// - Compat discovery set: directed discovery ends at timeout reporting success.
// - Centre frequency is 2405 MHz plus 5 MHz per channel above 11.
// - Accept traffic only with matching network identifier and channel.
// - Identifier 0xFFFF sends to all networks but does not widen reception.
// - Short destination when upper half zero and lower half below 0xFFFF.
// - Destination 0xFFFF is broadcast and the end-device polling address.
// - Both destination halves address transparent sends and sample reports.
// - Own short address 0xFFFF discards packets with 16-bit destinations.
// - Packets to the own 64-bit address pass the address check whatever the own short address is.
// - Compat discovery set, plain discovery in frame mode, no replies: send 0x88 OK frame.
// - Discovery timeout counts 100 ms units, legal 0x1 to 0xFC.
module lcac_top
  import lcac_pkg::*;
#(
  parameter int TICK_CYCLES = DISC_UNIT_CYCLES,
  parameter int TX_SLOTS    = 4
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        cfg_wr,
  input  wire logic                        cfg_rd,
  input  wire logic [3:0]                  cfg_sel,
  input  wire logic [31:0]                 cfg_wdata,
  output logic [31:0]                      cfg_rdata,
  output logic                             cfg_rvalid,
  output logic                             cfg_ok,
  output logic                             cfg_refused,
  input  wire logic [1:0]                  header_mode_sel,
  input  wire logic                        encryption_on,
  input  wire logic [63:0]                 own_long_addr,
  output logic [11:0]                      freq_mhz,
  output logic [6:0]                       max_payload,
  output logic [63:0]                      dest_addr,
  output logic                             dest_short,
  output logic                             dest_bcast,
  output logic                             tx_all_pans,
  input  wire logic                        tx_req,
  input  wire logic [63:0]                 tx_dest,
  input  wire logic                        tx_done,
  input  wire logic [$clog2(TX_SLOTS)-1:0] tx_done_slot,
  output logic                             tx_grant,
  output logic [$clog2(TX_SLOTS)-1:0]      tx_grant_slot,
  input  wire logic                        rx_valid,
  input  wire lcac_rx_type                 rx_hdr,
  output logic                             rx_accept,
  output logic                             rx_drop,
  input  wire logic                        discovery_cmd,
  input  wire logic                        disc_directed,
  input  wire logic                        disc_frame_mode,
  input  wire logic                        disc_reply,
  output logic                             disc_busy,
  output logic                             disc_done,
  output logic                             disc_ok,
  output logic                             disc_err,
  output logic                             resp_valid,
  output logic [7:0]                       resp_type
);

  typedef struct packed {
    lcac_cfg_type  cfg;
    logic [31:0]   rdata;
    logic          rvalid;
    logic          ok;
    logic          refused;
    logic [11:0]   freq;
    logic [6:0]    pay;
    logic          dshort;
    logic          dbcast;
    logic          allpan;
    logic          acc;
    logic          drop;
    lcac_disc_type dst;
    logic          directed;
    logic          frame;
    logic          replied;
    logic          done;
    logic          dok;
    logic          derr;
    logic          rvld;
  } lcac_state_type;

  lcac_state_type state;
  lcac_state_type next_state;
  logic           tmr_start;
  logic           tmr_abort;
  logic           tmr_expired;
  logic           tx_compat;
  logic           disc_compat;
  logic [6:0]     pay_calc;
  logic           dst_match;

  assign tx_compat   = state.cfg.compat[COMPAT_TX_BIT];
  assign disc_compat = state.cfg.compat[COMPAT_DISC_BIT];

  // Payload limit: legacy caps are fixed, otherwise each overhead costs bytes.
  always_comb
  begin
    pay_calc = PAY_BEST;
    if (header_mode_sel == 2'h0 || header_mode_sel == 2'h3)
    begin
      pay_calc = pay_calc - PAY_APP_HDR;
    end
    if (state.cfg.own_short == ADDR16_NO_SHRT || state.cfg.own_short == ADDR16_ALL)
    begin
      pay_calc = pay_calc - PAY_LONG_SRC;
    end
    if (!state.dshort)
    begin
      pay_calc = pay_calc - PAY_LONG_DST;
    end
    if (encryption_on)
    begin
      pay_calc = pay_calc - PAY_ENC_COST;
    end
    if (tx_compat)
    begin
      pay_calc = encryption_on ? PAY_OLD_ENC : PAY_OLD_PLAIN;
    end
  end

  // A short destination matches the own short address or the all-nodes value, unless the own short address is 0xFFFF.
  always_comb
  begin
    if (rx_hdr.dst_long)
    begin
      dst_match = (rx_hdr.dst == own_long_addr);
    end
    else
    begin
      dst_match = (state.cfg.own_short != ADDR16_ALL)
        && ((rx_hdr.dst[15:0] == state.cfg.own_short) || (rx_hdr.dst[15:0] == ADDR16_ALL));
    end
  end

  // Timer starts with a discovery and is cut short when a reply ends it early.
  assign tmr_start = discovery_cmd && (state.dst == DISC_IDLE);
  assign tmr_abort = (state.dst == DISC_WAIT) && state.directed && !disc_compat
    && disc_reply;

  always_comb
  begin
    next_state = state;
    next_state.rvalid  = 1'b0;
    next_state.ok      = 1'b0;
    next_state.refused = 1'b0;
    next_state.acc     = 1'b0;
    next_state.drop    = 1'b0;
    next_state.done    = 1'b0;
    next_state.dok     = 1'b0;
    next_state.derr    = 1'b0;
    next_state.rvld    = 1'b0;
    // Writes are refused while a discovery holds the command path.
    if (cfg_wr && state.dst == DISC_WAIT)
    begin
      next_state.refused = 1'b1;
    end
    else if (cfg_wr)
    begin
      next_state.ok = 1'b1;
      if (cfg_sel == SEL_COMPAT)
      begin
        next_state.cfg.compat = cfg_wdata[1:0];
      end
      else if (cfg_sel == SEL_CHANNEL)
      begin
        next_state.cfg.channel = cfg_wdata[7:0];
      end
      else if (cfg_sel == SEL_PAN)
      begin
        next_state.cfg.pan = cfg_wdata[15:0];
      end
      else if (cfg_sel == SEL_DEST_UP)
      begin
        next_state.cfg.dest_up = cfg_wdata;
      end
      else if (cfg_sel == SEL_DEST_LO)
      begin
        next_state.cfg.dest_lo = cfg_wdata;
      end
      else if (cfg_sel == SEL_OWN_SHORT)
      begin
        next_state.cfg.own_short = cfg_wdata[15:0];
      end
      else if (cfg_sel == SEL_TIMEOUT && cfg_wdata[7:0] >= TIMEOUT_MIN
        && cfg_wdata[7:0] <= TIMEOUT_MAX && cfg_wdata[31:8] == 24'h0)
      begin
        next_state.cfg.timeout = cfg_wdata[7:0];
      end
      else
      begin
        next_state.ok = 1'b0;
        next_state.refused = 1'b1;
      end
    end
    // Reads return the stored value, narrower fields zero-extended.
    if (cfg_rd)
    begin
      next_state.rvalid = 1'b1;
      if (cfg_sel == SEL_COMPAT)
      begin
        next_state.rdata = {30'h0, state.cfg.compat};
      end
      else if (cfg_sel == SEL_CHANNEL)
      begin
        next_state.rdata = {24'h0, state.cfg.channel};
      end
      else if (cfg_sel == SEL_PAN)
      begin
        next_state.rdata = {16'h0, state.cfg.pan};
      end
      else if (cfg_sel == SEL_DEST_UP)
      begin
        next_state.rdata = state.cfg.dest_up;
      end
      else if (cfg_sel == SEL_DEST_LO)
      begin
        next_state.rdata = state.cfg.dest_lo;
      end
      else if (cfg_sel == SEL_OWN_SHORT)
      begin
        next_state.rdata = {16'h0, state.cfg.own_short};
      end
      else if (cfg_sel == SEL_TIMEOUT)
      begin
        next_state.rdata = {24'h0, state.cfg.timeout};
      end
      else if (cfg_sel == SEL_STATUS)
      begin
        next_state.rdata = {25'h0, state.pay};
        next_state.rdata[31] = (state.dst == DISC_WAIT);
      end
      else
      begin
        next_state.rdata = 32'h0;
      end
    end
    // Derived settings, one cycle behind the stored configuration; the payload limit lags destination changes by two.
    next_state.freq = 12'(FREQ_BASE_MHZ - FREQ_STEP_MHZ * FREQ_BASE_CH)
      + 12'(state.cfg.channel) * 12'(FREQ_STEP_MHZ);
    next_state.dshort = (state.cfg.dest_up == 32'h0)
      && (state.cfg.dest_lo < DEST_LO_BCAST);
    next_state.dbcast = (state.cfg.dest_up == 32'h0)
      && (state.cfg.dest_lo == DEST_LO_BCAST);
    next_state.allpan = (state.cfg.pan == PAN_ALL);
    next_state.pay = pay_calc;
    // Reception needs own network and channel; the all-networks id is not a wildcard.
    if (rx_valid)
    begin
      if (rx_hdr.pan == state.cfg.pan && rx_hdr.channel == state.cfg.channel
        && dst_match)
      begin
        next_state.acc = 1'b1;
      end
      else
      begin
        next_state.drop = 1'b1;
      end
    end
    // Discovery sequencing.
    case (state.dst)
      DISC_IDLE:
      begin
        if (discovery_cmd)
        begin
          next_state.dst = DISC_WAIT;
          next_state.directed = disc_directed;
          next_state.frame = disc_frame_mode;
          next_state.replied = 1'b0;
        end
      end
      DISC_WAIT:
      begin
        if (disc_reply)
        begin
          next_state.replied = 1'b1;
        end
        if (tmr_abort)
        begin
          next_state.dst = DISC_IDLE;
          next_state.done = 1'b1;
          next_state.dok = 1'b1;
        end
        else if (tmr_expired)
        begin
          next_state.dst = DISC_IDLE;
          next_state.done = 1'b1;
          if (state.directed && disc_compat)
          begin
            next_state.dok = 1'b1;
          end
          else if (state.directed)
          begin
            next_state.derr = 1'b1;
          end
          else if (disc_compat && state.frame && !state.replied && !disc_reply)
          begin
            next_state.dok = 1'b1;
            next_state.rvld = 1'b1;
          end
        end
      end
      default:
      begin
        next_state.dst = DISC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.cfg <= '{RST_COMPAT, RST_CHANNEL, RST_PAN, RST_DEST_UP, RST_DEST_LO,
                     RST_OWN_SHORT, RST_TIMEOUT};
      state.dst <= DISC_IDLE;
      state.pay <= PAY_BEST;
      state.freq <= 12'(FREQ_BASE_MHZ + FREQ_STEP_MHZ);
      state.dshort <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Discovery timeout timer in 100 ms units.
  lcac_disc_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (tmr_start),
    .abort    (tmr_abort),
    .units    (state.cfg.timeout),
    .expired  (tmr_expired)
  );

  // Transmit admission; the legacy setting allows one active message only.
  lcac_tx_gate #(.SLOTS(TX_SLOTS)) u_gate (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .single     (tx_compat),
    .req        (tx_req),
    .dest       (tx_dest),
    .done       (tx_done),
    .done_slot  (tx_done_slot),
    .grant      (tx_grant),
    .grant_slot (tx_grant_slot)
  );

  // Output map; the full destination feeds transparent sends and sample reports.
  assign cfg_rdata   = state.rdata;
  assign cfg_rvalid  = state.rvalid;
  assign cfg_ok      = state.ok;
  assign cfg_refused = state.refused;
  assign freq_mhz    = state.freq;
  assign max_payload = state.pay;
  assign dest_addr   = {state.cfg.dest_up, state.cfg.dest_lo};
  assign dest_short  = state.dshort;
  assign dest_bcast  = state.dbcast;
  assign tx_all_pans = state.allpan;
  assign rx_accept   = state.acc;
  assign rx_drop     = state.drop;
  assign disc_busy   = (state.dst == DISC_WAIT);
  assign disc_done   = state.done;
  assign disc_ok     = state.dok;
  assign disc_err    = state.derr;
  assign resp_valid  = state.rvld;
  assign resp_type   = FRAME_CMD_RESP;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  freq_map_a: assert property (##1 freq_mhz == 12'(2350) + 12'($past(state.cfg.channel)) * 12'(5))
    else $error("Frequency does not follow channel.");
  legacy_cap_a: assert property (##1 $past(tx_compat) |-> max_payload == ($past(encryption_on)
    ? 7'd95 : 7'd100)) else $error("Legacy payload cap wrong.");
  short_dest_a: assert property (##1 dest_short == ($past(state.cfg.dest_up) == 32'h0
    && $past(state.cfg.dest_lo) < 32'hFFFF)) else $error("Short destination choice wrong.");
  short_drop_a: assert property (rx_valid && !rx_hdr.dst_long && state.cfg.own_short == 16'hFFFF
    |=> !rx_accept && rx_drop) else $error("Short packet accepted with 0xFFFF.");
  pan_match_a: assert property (rx_valid && rx_hdr.pan != state.cfg.pan |=> !rx_accept)
    else $error("Foreign network accepted.");
  busy_refuse_a: assert property (cfg_wr && disc_busy |=> cfg_refused && !cfg_ok
    && $stable(state.cfg)) else $error("Write taken during discovery.");
  early_end_a: assert property (disc_busy && state.directed && !disc_compat && disc_reply
    |=> disc_done && disc_ok && !disc_busy) else $error("Directed reply did not end.");
  legacy_hold_a: assert property (disc_busy && state.directed && disc_compat && !tmr_expired
    |=> disc_busy && !disc_done) else $error("Legacy discovery ended early.");
  legacy_ok_a: assert property (disc_busy && state.directed && disc_compat && tmr_expired
    |=> disc_ok && !disc_err) else $error("Legacy discovery did not succeed.");
  timeout_err_a: assert property (disc_busy && state.directed && !disc_compat && tmr_expired
    && !disc_reply |=> disc_err) else $error("Missing error at timeout.");
  frame_ok_a: assert property (resp_valid |-> resp_type == 8'h88 && disc_ok && disc_done)
    else $error("Empty-discovery frame malformed.");

endmodule : lcac_top

/* common/lcac_pkg.sv */
// Package with register selects, reset values, limits and timing for the config block.
package lcac_pkg;

  // Register selects on the configuration command port.
  localparam logic [3:0] SEL_COMPAT    = 4'h0;
  localparam logic [3:0] SEL_CHANNEL   = 4'h1;
  localparam logic [3:0] SEL_PAN       = 4'h2;
  localparam logic [3:0] SEL_DEST_UP   = 4'h3;
  localparam logic [3:0] SEL_DEST_LO   = 4'h4;
  localparam logic [3:0] SEL_OWN_SHORT = 4'h5;
  localparam logic [3:0] SEL_TIMEOUT   = 4'h6;
  localparam logic [3:0] SEL_STATUS    = 4'h7;

  // Reset values.
  localparam logic [1:0]  RST_COMPAT    = 2'h0;
  localparam logic [7:0]  RST_CHANNEL   = 8'h0C;
  localparam logic [15:0] RST_PAN       = 16'h3332;
  localparam logic [31:0] RST_DEST_UP   = 32'h0;
  localparam logic [31:0] RST_DEST_LO   = 32'h0;
  localparam logic [15:0] RST_OWN_SHORT = 16'h0;
  localparam logic [7:0]  RST_TIMEOUT   = 8'h19;

  // Field positions inside the compatibility bits.
  localparam int COMPAT_TX_BIT   = 0;
  localparam int COMPAT_DISC_BIT = 1;

  // Special address values, timeout range and response frame type.
  localparam logic [15:0] ADDR16_ALL     = 16'hFFFF;
  localparam logic [15:0] ADDR16_NO_SHRT = 16'hFFFE;
  localparam logic [15:0] PAN_ALL        = 16'hFFFF;
  localparam logic [31:0] DEST_LO_BCAST  = 32'h0000FFFF;
  localparam logic [7:0]  TIMEOUT_MIN    = 8'h01;
  localparam logic [7:0]  TIMEOUT_MAX    = 8'hFC;
  localparam logic [7:0]  FRAME_CMD_RESP = 8'h88;

  // Payload limits and overhead costs in bytes.
  localparam logic [6:0] PAY_BEST      = 7'd116;
  localparam logic [6:0] PAY_OLD_ENC   = 7'd95;
  localparam logic [6:0] PAY_OLD_PLAIN = 7'd100;
  localparam logic [6:0] PAY_APP_HDR   = 7'd4;
  localparam logic [6:0] PAY_LONG_SRC  = 7'd6;
  localparam logic [6:0] PAY_LONG_DST  = 7'd6;
  localparam logic [6:0] PAY_ENC_COST  = 7'd8;

  // Channel to centre frequency mapping.
  localparam int FREQ_BASE_MHZ = 2405;
  localparam int FREQ_STEP_MHZ = 5;
  localparam int FREQ_BASE_CH  = 11;

  // Discovery timeout unit, in its own unit and in clock cycles.
  localparam int CLK_PERIOD_NS     = 25;
  localparam int DISC_UNIT_MS      = 100;
  localparam int DISC_UNIT_CYCLES  = DISC_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  // Settings held by the block.
  typedef struct packed {
    logic [1:0]  compat;
    logic [7:0]  channel;
    logic [15:0] pan;
    logic [31:0] dest_up;
    logic [31:0] dest_lo;
    logic [15:0] own_short;
    logic [7:0]  timeout;
  } lcac_cfg_type;

  // Header of a received frame offered to the filter.
  typedef struct packed {
    logic [15:0] pan;
    logic [7:0]  channel;
    logic        dst_long;
    logic [63:0] dst;
  } lcac_rx_type;

  typedef enum logic [1:0] {DISC_IDLE, DISC_WAIT} lcac_disc_type;

endpackage : lcac_pkg

/* rtl/lcac_disc_timer.sv */
// Discovery timeout timer counting in 100 ms units.
module lcac_disc_timer
  import lcac_pkg::*;
#(
  parameter int TICK_CYCLES = DISC_UNIT_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [7:0] units,
  output logic            expired
);

  typedef struct packed {
    logic        run;
    logic [31:0] tick;
    logic [7:0]  left;
    logic        expired;
  } lcac_tmr_type;

  lcac_tmr_type state;
  lcac_tmr_type next_state;

  // Prescale to units, then count units down; expiry is a one-cycle pulse.
  always_comb
  begin
    next_state = state;
    next_state.expired = 1'b0;
    if (abort)
    begin
      next_state.run = 1'b0;
    end
    else if (start)
    begin
      next_state.run = 1'b1;
      next_state.tick = 32'(TICK_CYCLES - 1);
      next_state.left = units;
    end
    else if (state.run)
    begin
      if (state.tick != 32'h0)
      begin
        next_state.tick = state.tick - 32'h1;
      end
      else if (state.left <= 8'h01)
      begin
        next_state.run = 1'b0;
        next_state.expired = 1'b1;
      end
      else
      begin
        next_state.left = state.left - 8'h01;
        next_state.tick = 32'(TICK_CYCLES - 1);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign expired = state.expired;

endmodule : lcac_disc_timer

/* rtl/lcac_tx_gate.sv */
// Admission gate for the active transmit queue, one slot per active message.
module lcac_tx_gate
  import lcac_pkg::*;
#(
  parameter int SLOTS = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     single,
  input  wire logic                     req,
  input  wire logic [63:0]              dest,
  input  wire logic                     done,
  input  wire logic [$clog2(SLOTS)-1:0] done_slot,
  output logic                          grant,
  output logic [$clog2(SLOTS)-1:0]      grant_slot
);

  typedef struct packed {
    logic [SLOTS-1:0]       busy;
    logic [SLOTS-1:0][63:0] dst;
    logic                   grant;
    logic [$clog2(SLOTS)-1:0] slot;
  } lcac_gate_type;

  lcac_gate_type state;
  lcac_gate_type next_state;
  logic [SLOTS-1:0] same;

  // Per-slot check for a message already in flight to the same destination.
  for (genvar i = 0; i < SLOTS; i++)
  begin : g_cmp
    assign same[i] = state.busy[i] && (state.dst[i] == dest);
  end

  // The head request waits while blocked, so order per destination holds.
  always_comb
  begin
    next_state = state;
    next_state.grant = 1'b0;
    if (done)
    begin
      next_state.busy[done_slot] = 1'b0;
    end
    if (req && !state.grant && (same == '0) && !(single && (state.busy != '0)))
    begin
      for (int k = SLOTS - 1; k >= 0; k--)
      begin
        if (!state.busy[k])
        begin
          next_state.slot = k[$clog2(SLOTS)-1:0];
        end
      end
      if (state.busy != '1)
      begin
        next_state.grant = 1'b1;
        next_state.busy[next_state.slot] = 1'b1;
        next_state.dst[next_state.slot] = dest;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign grant = state.grant;
  assign grant_slot = state.slot;

endmodule : lcac_tx_gate

/* dv/lcac_node_model.sv */
// Far radio node model that sends frames and discovery replies.
module lcac_node_model
  import lcac_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         send,
  input  wire lcac_rx_type  hdr,
  input  wire logic         answer,
  output logic              rx_valid = 1'b0,
  output lcac_rx_type       rx_hdr = '0,
  output logic              disc_reply = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle header lines flip every cycle so a stale frame cannot pass as fresh.
  always_ff @(posedge core_clk)
  begin
    rx_valid   <= send;
    rx_hdr     <= send ? hdr : ~rx_hdr;
    disc_reply <= answer;
  end
endmodule : lcac_node_model

/* dv/lcac_top_tb_top.sv */
// Testbench for the config block with a far node model.
module lcac_top_tb_top
  import lcac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, encryption_on = 0, tx_req = 0;
  logic tx_done = 0, discovery_cmd = 0, disc_directed = 0, disc_frame_mode = 0;
  logic send = 0, answer = 0;
  logic [1:0] header_mode_sel = 2'h1, tx_done_slot = 2'h0, tx_grant_slot, s0, s1;
  logic [3:0] cfg_sel = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [63:0] own_long_addr = 64'hA5A5_0000_1234_5678, tx_dest = 64'h0, dest_addr;
  logic cfg_rvalid, cfg_ok, cfg_refused, dest_short, dest_bcast, tx_all_pans, tx_grant;
  logic rx_valid, rx_accept, rx_drop, disc_reply, disc_busy, disc_done, disc_ok, disc_err;
  logic resp_valid;
  logic [11:0] freq_mhz;
  logic [6:0] max_payload;
  logic [7:0] resp_type;
  lcac_rx_type hdr = '0, rx_hdr;
  int n_mismatch = 0, checked = 0;
  lcac_top #(.TICK_CYCLES(4)) i_dut (.core_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_sel,
    .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_ok, .cfg_refused, .header_mode_sel,
    .encryption_on, .own_long_addr, .freq_mhz, .max_payload, .dest_addr, .dest_short,
    .dest_bcast, .tx_all_pans, .tx_req, .tx_dest, .tx_done, .tx_done_slot, .tx_grant,
    .tx_grant_slot, .rx_valid, .rx_hdr, .rx_accept, .rx_drop, .discovery_cmd, .disc_directed,
    .disc_frame_mode, .disc_reply, .disc_busy, .disc_done, .disc_ok, .disc_err, .resp_valid,
    .resp_type);
  lcac_node_model i_node (.core_clk, .send, .hdr, .answer, .rx_valid, .rx_hdr, .disc_reply);
  // Free running core clock.
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Inputs move 1 ns after the edge so no race with the design's sampling.
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // One configuration command; the answer pulse is visible on return.
  task automatic cfg(input logic wr, input logic [3:0] s, input logic [31:0] d);
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_sel = s;
    cfg_wdata = d;
    tick;
    cfg_wr = 0;
    cfg_rd = 0;
  endtask : cfg
  // Reset values read back, and derived outputs after reset.
  task automatic t_regs;
    logic [31:0] rv [7] = '{32'h0, 32'hC, 32'h3332, 32'h0, 32'h0, 32'h0, 32'h19};
    for (int i = 0; i < 7; i++)
    begin
      cfg(0, i[3:0], 32'h0);
      chk("cfg_rdata", cfg_rdata, rv[i]);
      chk("cfg_rvalid", cfg_rvalid, 1);
    end
    chk("freq_mhz", freq_mhz, FREQ_BASE_MHZ + FREQ_STEP_MHZ);
    chk("max_payload", max_payload, 116);
    cfg(1, SEL_COMPAT, 32'h1);
    tick;
    chk("max_payload", max_payload, 100);
    encryption_on = 1;
    tick;
    tick;
    chk("max_payload", max_payload, 95);
    encryption_on = 0;
    cfg(1, SEL_CHANNEL, 32'h1A);
    tick;
    chk("freq_mhz", freq_mhz, FREQ_BASE_MHZ + FREQ_STEP_MHZ * (26 - FREQ_BASE_CH));
  endtask : t_regs
  // Destination kind; an upper half of one forces the long form.
  task automatic t_dest;
    cfg(1, SEL_DEST_LO, 32'hFFFF);
    tick;
    chk("dest_bcast", dest_bcast, 1);
    chk("dest_short", dest_short, 0);
    cfg(1, SEL_DEST_UP, 32'h1);
    cfg(1, SEL_DEST_LO, 32'hFFFE);
    tick;
    chk("dest_addr", dest_addr, 64'h1_0000_FFFE);
    chk("dest_short", dest_short, 0);
    cfg(1, SEL_DEST_UP, 32'h0);
    chk("cfg_ok", cfg_ok, 1);
    tick;
    chk("dest_short", dest_short, 1);
  endtask : t_dest
  // Timeout range edges; ends with a short timeout of 3 units.
  task automatic t_tout;
    logic [7:0] v [4] = '{8'h00, 8'hFD, 8'hFC, 8'h03};
    for (int i = 0; i < 4; i++)
    begin
      cfg(1, SEL_TIMEOUT, {24'h0, v[i]});
      chk("cfg_refused", cfg_refused, v[i] < TIMEOUT_MIN || v[i] > TIMEOUT_MAX);
    end
  endtask : t_tout
  // One frame through the node model; accept or drop one cycle after it arrives.
  task automatic frame(input lcac_rx_type h, input logic acc);
    hdr = h;
    send = 1;
    tick;
    send = 0;
    tick;
    chk("rx_accept", rx_accept, acc);
    chk("rx_drop", rx_drop, !acc);
  endtask : frame
  // Receive filtering on network, channel and addresses.
  task automatic t_rx;
    frame('{16'h3332, 8'h1A, 1'b0, 64'h0}, 1);
    frame('{16'h3333, 8'h1A, 1'b0, 64'h0}, 0);
    frame('{16'h3332, 8'h1B, 1'b0, 64'h0}, 0);
    cfg(1, SEL_PAN, 32'hFFFF);
    tick;
    chk("tx_all_pans", tx_all_pans, 1);
    frame('{16'h1234, 8'h1A, 1'b0, 64'h0}, 0);
    cfg(1, SEL_OWN_SHORT, 32'hFFFF);
    frame('{16'hFFFF, 8'h1A, 1'b0, 64'hFFFF}, 0);
    frame('{16'hFFFF, 8'h1A, 1'b1, own_long_addr}, 1);
  endtask : t_rx
  // Head request waits a bounded time; it is held while blocked.
  task automatic req(input logic [63:0] d, input logic exp, output logic [1:0] s);
    tx_dest = d;
    tx_req = 1;
    repeat (6) if (tx_grant !== 1'b1) tick;
    chk("tx_grant", tx_grant, exp);
    s = tx_grant_slot;
    tx_req = !tx_grant;
    tick;
  endtask : req
  task automatic done(input logic [1:0] s);
    tx_done = 1;
    tx_done_slot = s;
    tick;
    tx_done = 0;
  endtask : done
  // Active queue admission in both transmit modes.
  task automatic t_tx;
    cfg(1, SEL_COMPAT, 32'h0);
    req(64'hA, 1, s0);
    req(64'hB, 1, s1);
    chk("tx_grant_slot", s1, 1);
    req(64'hA, 0, s1);
    done(s0);
    req(64'hA, 1, s0);
    done(s0);
    done(s1);
    cfg(1, SEL_COMPAT, 32'h1);
    req(64'hA, 1, s0);
    req(64'hB, 0, s1);
    done(s0);
    req(64'hB, 1, s1);
    done(s1);
  endtask : t_tx
  // One discovery; a write during a long discovery must be refused.
  task automatic disc(input logic [1:0] c, input logic dir, fm, rep, ok, err, rv);
    int k;
    logic early;
    early = rep & dir & !c[1];
    cfg(1, SEL_COMPAT, {30'h0, c});
    disc_directed = dir;
    disc_frame_mode = fm;
    discovery_cmd = 1;
    tick;
    discovery_cmd = 0;
    answer = rep;
    tick;
    answer = 0;
    chk("disc_busy", disc_busy, 1);
    if (!early)
    begin
      cfg(1, SEL_CHANNEL, 32'h1A);
      chk("cfg_refused", cfg_refused, 1);
    end
    for (k = 0; k < 40 && disc_done !== 1'b1; k++) tick;
    chk("disc_done", disc_done, 1);
    chk("disc_ok", disc_ok, ok);
    chk("disc_err", disc_err, err);
    chk("resp_valid", resp_valid, rv);
    if (rv) chk("resp_type", resp_type, FRAME_CMD_RESP);
    chk("ends_early", k < 4, early);
    tick;
  endtask : disc
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // A hang trips this limit; the run is a few hundred cycles.
  initial
  begin
    #100us;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (2) tick;
    rst_n = 1;
    t_regs;
    t_dest;
    t_tout;
    t_rx;
    t_tx;
    disc(2'b00, 1, 0, 1, 1, 0, 0);
    disc(2'b00, 1, 0, 0, 0, 1, 0);
    disc(2'b10, 1, 0, 1, 1, 0, 0);
    disc(2'b10, 1, 0, 0, 1, 0, 0);
    disc(2'b10, 0, 1, 0, 1, 0, 1);
    test_done;
  end
endmodule : lcac_top_tb_top
